// ==== rtl/wake_pkg.sv ====
// Shared constants and types for the wake-event signaller
package wake_pkg;
  localparam int ADDR_W = 8;
  localparam int NPIN = 12;
  localparam int LEN_W = 8;
  // Register offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_PULSE = 8'h04;
  localparam logic [7:0] OFS_WAKE_EN = 8'h08;
  localparam logic [7:0] OFS_PIN_POL = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MAC_LO = 8'h14;
  localparam logic [7:0] OFS_MAC_HI = 8'h18;
  localparam logic [7:0] OFS_CTRL = 8'h1C;
  // Configuration field positions
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_STYLE_BIT = 1;
  localparam int CFG_POL_BIT = 2;
  localparam int CFG_DRIVE_BIT = 3;
  localparam int CFG_NETSEL_BIT = 4;
  localparam int CFG_POWER_BIT = 5;
  localparam int CFG_DETACH_BIT = 6;
  localparam int CTRL_ENTER_BIT = 0;
  // Status field positions
  localparam int ST_WAIT_BIT = 0;
  localparam int ST_EVENT_BIT = 1;
  localparam int ST_DETACH_BIT = 2;
  localparam int ST_AVAIL_BIT = 3;
  localparam int ST_MODESEL_BIT = 4;
  localparam int ST_VBUS_BIT = 5;
  // Reset values
  localparam logic [6:0] CFG_RESET = 7'h00;
  localparam logic [7:0] PULSE_RESET = 8'h10;
  localparam logic [11:0] WAKE_EN_RESET = 12'h000;
  localparam logic [11:0] PIN_POL_RESET = 12'h000;
  localparam logic [47:0] MAC_RESET = 48'h000000000000;
  // Pin roles
  localparam int WAKE_PIN = 5;
  localparam int MODE_PIN = 6;
  localparam logic [11:0] WAKE_CAPABLE_MASK = 12'h79F;
  typedef enum logic [1:0] {ST_NORMAL, ST_WAKE_WAIT, ST_DETACHED} mode_e;
endpackage

// ==== rtl/wake_if.sv ====
// Carrier between the wake core, pin detector and pulse timer
`timescale 1ns/10ps
interface wake_if;
  logic [11:0] pins;
  logic [11:0] pol;
  logic [11:0] en;
  logic [11:0] hit;
  logic trig;
  logic [7:0] len;
  logic busy;
  modport detect (input pins, input pol, input en, output hit);
  modport pulse (input trig, input len, output busy);
endinterface

// ==== rtl/pin_wake_detect.sv ====
// Per-pin wake qualification
`timescale 1ns/10ps
module pin_wake_detect (
  input wire logic i_clk,
  input wire logic i_reset_n,
  wake_if.detect w
);
  logic [11:0] hit_r;

  // One flop per pin: active level, enable and capability all required
  genvar g;
  for (g = 0; g < wake_pkg::NPIN; g++) begin : g_pin
    always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        hit_r[g] <= 1'b0;
      end else begin
        hit_r[g] <= w.en[g] & wake_pkg::WAKE_CAPABLE_MASK[g] & (w.pins[g] == w.pol[g]);
      end
    end
  end

  assign w.hit = hit_r;
endmodule

// ==== rtl/wake_pulse_timer.sv ====
// Pulse-length timer for pulse-style wake signalling
`timescale 1ns/10ps
module wake_pulse_timer (
  input wire logic i_clk,
  input wire logic i_reset_n,
  wake_if.pulse w
);
  logic [7:0] cnt_r;

  // Load on trigger, count down to zero; zero length acts as one
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_r <= 8'h00;
    end else if (w.trig) begin
      cnt_r <= (w.len == 8'h00) ? 8'h01 : w.len;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  assign w.busy = (cnt_r != 8'h00);
endmodule

// ==== rtl/usb_ether_wake_event_signaler.sv ====
// Wake-event signaller: wake-waiting mode, wake sources, clear and detach
//
// Overview of operation
// - Wake signalling needs self-powered plus valid EEPROM.
// - Pin 5 signals wake, pin 6 selects mode.
// - Mode select sampled when clear reset asserts.
// - Sample 1 keeps waiting, 0 returns normal.
// - Enabled wake event drives wake output.
// - Pin wakes only if its enable bit set.
// - Signalling pins ignore their enable bits.
// - Pins 0-4, 7-10 wake, active low default.
// - Wake-on-LAN packet raises wake output.
// - Own destination address match raises wake.
// - Link partner detection raises wake output.
// - Clear while waiting requests EEPROM reload.
// - Style flag 0 gives steady level.
// - Polarity 1 high active, drive 1 push-pull.
// - Network select 0 uses wake-on-LAN packet.
// - Power-method flag 1 means self-powered.
// - Cable unplug detaches, low power while detached.
// - Cable plug or pin reattaches automatically.
`timescale 1ns/10ps
module usb_ether_wake_event_signaler (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_chip_reset_n,
  input wire logic [11:0] i_gpio,
  input wire logic i_bus_power_detect,
  input wire logic i_eeprom_valid,
  input wire logic i_wol_pkt,
  input wire logic i_rx_da_valid,
  input wire logic [47:0] i_rx_da,
  input wire logic i_link_up,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_wake_event_pin,
  output logic o_wake_event_pin_oe,
  output logic o_reload_req,
  output logic o_usb_attach,
  output logic o_low_power,
  output logic o_wake_mode
);
  wake_pkg::mode_e state_r;
  wake_pkg::mode_e state_nxt;
  logic [6:0] cfg_r;
  logic [7:0] pulse_len_r;
  logic [11:0] wake_en_r;
  logic [11:0] pin_pol_r;
  logic [47:0] mac_r;
  logic [31:0] rdata_r;
  logic clr_d_r;
  logic link_d_r;
  logic mode_sel_r;
  logic event_r;
  logic da_hit_r;
  logic reload_r;
  logic pin_r;
  logic oe_r;
  logic clr_fall;
  logic clr_rise;
  logic link_rise;
  logic link_fall;
  logic avail;
  logic waiting;
  logic can_fire;
  logic net_src;
  logic gpio_any;
  logic fire;
  logic enter_req;
  logic active;
  logic cfg_enable;
  logic cfg_style;
  logic cfg_pol;
  logic cfg_drive;
  logic cfg_netsel;
  logic cfg_power;
  logic cfg_detach;

  wake_if wi ();

  // Configuration flag views
  assign cfg_enable = cfg_r[wake_pkg::CFG_ENABLE_BIT];
  assign cfg_style = cfg_r[wake_pkg::CFG_STYLE_BIT];
  assign cfg_pol = cfg_r[wake_pkg::CFG_POL_BIT];
  assign cfg_drive = cfg_r[wake_pkg::CFG_DRIVE_BIT];
  assign cfg_netsel = cfg_r[wake_pkg::CFG_NETSEL_BIT];
  assign cfg_detach = cfg_r[wake_pkg::CFG_DETACH_BIT];
  assign cfg_power = cfg_r[wake_pkg::CFG_POWER_BIT];

  assign avail = cfg_power & i_eeprom_valid;

  // Edges of the clear reset and the link status
  assign clr_fall = clr_d_r & ~i_chip_reset_n;
  assign clr_rise = ~clr_d_r & i_chip_reset_n;
  assign link_rise = ~link_d_r & i_link_up;
  assign link_fall = link_d_r & ~i_link_up;
  assign waiting = (state_r == wake_pkg::ST_WAKE_WAIT);
  assign enter_req = i_wr & (i_addr == wake_pkg::OFS_CTRL) & i_wdata[wake_pkg::CTRL_ENTER_BIT];

  // Pin detector inputs
  assign wi.pins = i_gpio;
  assign wi.pol = pin_pol_r;
  // per-pin enables from the 12-bit wake enable register
  assign wi.en = wake_en_r;
  assign gpio_any = |wi.hit;

  pin_wake_detect u_pins (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .w(wi.detect)
  );

  assign net_src = cfg_netsel ? da_hit_r : i_wol_pkt;

  // wake sources while waiting, blocked during clear
  assign can_fire = waiting & cfg_enable & i_chip_reset_n;
  assign fire = can_fire & (gpio_any | net_src | link_rise);

  // Pulse timer starts on the first event only
  assign wi.trig = fire & ~event_r;
  assign wi.len = pulse_len_r;

  wake_pulse_timer u_pulse (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .w(wi.pulse)
  );

  assign active = cfg_style ? wi.busy : event_r;

  // Edge history flops
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      clr_d_r <= 1'b1;
      link_d_r <= 1'b0;
    end else begin
      clr_d_r <= i_chip_reset_n;
      link_d_r <= i_link_up;
    end
  end

  // catch mode select as the clear asserts
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_sel_r <= 1'b0;
    end else if (clr_fall) begin
      mode_sel_r <= i_gpio[wake_pkg::MODE_PIN];
    end
  end

  // exact match of destination against own address
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      da_hit_r <= 1'b0;
    end else begin
      da_hit_r <= i_rx_da_valid & (i_rx_da == mac_r);
    end
  end

  // event stays set until the clear reset asserts
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      event_r <= 1'b0;
    end else if (!i_chip_reset_n) begin
      event_r <= 1'b0;
    end else if (fire) begin
      event_r <= 1'b1;
    end
  end

  // reload request when cleared in wake-waiting mode
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      reload_r <= 1'b0;
    end else begin
      reload_r <= waiting & clr_fall;
    end
  end

  // Mode sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      wake_pkg::ST_NORMAL: begin
        if (enter_req && avail) begin
          state_nxt = wake_pkg::ST_WAKE_WAIT;
        end else if (cfg_detach && link_fall) begin
          state_nxt = wake_pkg::ST_DETACHED;
        end
      end
      wake_pkg::ST_WAKE_WAIT: begin
        if (!avail) begin
          state_nxt = wake_pkg::ST_NORMAL;
        // sampled select decides mode after the clear
        end else if (clr_rise) begin
          state_nxt = mode_sel_r ? wake_pkg::ST_WAKE_WAIT : wake_pkg::ST_NORMAL;
        end
      end
      wake_pkg::ST_DETACHED: begin
        // reattach on cable or programmed pin
        if (link_rise || gpio_any || !cfg_detach) begin
          state_nxt = wake_pkg::ST_NORMAL;
        end
      end
      default: begin
        state_nxt = wake_pkg::ST_NORMAL;
      end
    endcase
  end

  // Mode register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= wake_pkg::ST_NORMAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      pin_r <= active ? cfg_pol : ~cfg_pol;
      oe_r <= cfg_enable & (cfg_drive | ~(active ? cfg_pol : ~cfg_pol));
    end
  end

  // Register writes
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_r <= wake_pkg::CFG_RESET;
      pulse_len_r <= wake_pkg::PULSE_RESET;
      wake_en_r <= wake_pkg::WAKE_EN_RESET;
      pin_pol_r <= wake_pkg::PIN_POL_RESET;
      mac_r <= wake_pkg::MAC_RESET;
    end else if (i_wr) begin
      case (i_addr)
        wake_pkg::OFS_CFG: cfg_r <= i_wdata[6:0];
        wake_pkg::OFS_PULSE: pulse_len_r <= i_wdata[7:0];
        wake_pkg::OFS_WAKE_EN: wake_en_r <= i_wdata[11:0];
        wake_pkg::OFS_PIN_POL: pin_pol_r <= i_wdata[11:0];
        wake_pkg::OFS_MAC_LO: mac_r[31:0] <= i_wdata;
        wake_pkg::OFS_MAC_HI: mac_r[47:32] <= i_wdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // Register reads, data in the following cycle only
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_r <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        wake_pkg::OFS_CFG: rdata_r <= {25'h0000000, cfg_r};
        wake_pkg::OFS_PULSE: rdata_r <= {24'h000000, pulse_len_r};
        wake_pkg::OFS_WAKE_EN: rdata_r <= {20'h00000, wake_en_r};
        wake_pkg::OFS_PIN_POL: rdata_r <= {20'h00000, pin_pol_r};
        wake_pkg::OFS_MAC_LO: rdata_r <= mac_r[31:0];
        wake_pkg::OFS_MAC_HI: rdata_r <= {16'h0000, mac_r[47:32]};
        wake_pkg::OFS_STATUS: begin
          rdata_r <= 32'h00000000;
          rdata_r[wake_pkg::ST_WAIT_BIT] <= waiting;
          rdata_r[wake_pkg::ST_EVENT_BIT] <= event_r;
          rdata_r[wake_pkg::ST_DETACH_BIT] <= (state_r == wake_pkg::ST_DETACHED);
          rdata_r[wake_pkg::ST_AVAIL_BIT] <= avail;
          rdata_r[wake_pkg::ST_MODESEL_BIT] <= mode_sel_r;
          rdata_r[wake_pkg::ST_VBUS_BIT] <= i_bus_power_detect;
        end
        default: rdata_r <= 32'h00000000;
      endcase
    end else begin
      rdata_r <= 32'h00000000;
    end
  end

  // Outputs
  assign o_rdata = rdata_r;
  assign o_wake_event_pin = pin_r;
  assign o_wake_event_pin_oe = oe_r;
  assign o_reload_req = reload_r;
  assign o_usb_attach = (state_r != wake_pkg::ST_DETACHED);
  assign o_low_power = (state_r == wake_pkg::ST_DETACHED);
  assign o_wake_mode = waiting;

  // Checks on the wake core
  avail_gate_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(waiting) |-> $past(avail)) else $error("wake mode entered while unavailable");
  pin_reserved_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !(wi.hit[wake_pkg::WAKE_PIN] | wi.hit[wake_pkg::MODE_PIN]))
    else $error("signalling pin used as wake source");
  mode_sample_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    clr_fall |=> (mode_sel_r == $past(i_gpio[wake_pkg::MODE_PIN])))
    else $error("mode select not sampled at clear");
  stay_wait_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (waiting && clr_rise && avail) |=> (waiting == $past(mode_sel_r)))
    else $error("wrong mode after clear");
  fire_sets_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (fire && (!cfg_style || !event_r)) |=> event_r ##1 (pin_r == $past(cfg_pol)))
    else $error("wake event not raised");
  pin_enable_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (wi.hit != 12'h000) |-> (($past(wake_en_r) & wi.hit) == wi.hit))
    else $error("disabled pin produced a hit");
  wol_src_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (can_fire && !cfg_netsel && i_wol_pkt) |=> event_r)
    else $error("wake packet ignored");
  da_src_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (can_fire && cfg_netsel && i_rx_da_valid && i_rx_da == mac_r) |=> ##1 event_r)
    else $error("address match ignored");
  link_src_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (can_fire && link_rise) |=> event_r) else $error("link up ignored");
  reload_req_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (waiting && clr_fall) |=> o_reload_req) else $error("reload not requested");
  level_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (event_r && i_chip_reset_n) |=> event_r) else $error("level event dropped");
  level_pin_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (event_r && !cfg_style) |=> (o_wake_event_pin == $past(cfg_pol)))
    else $error("level not presented");
  push_pull_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (cfg_enable && cfg_drive) |=> o_wake_event_pin_oe) else $error("push-pull not driven");
  detach_go_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (state_r == wake_pkg::ST_NORMAL && !enter_req && cfg_detach && link_fall)
    |=> (o_low_power && !o_usb_attach)) else $error("no detach on unplug");
  reattach_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (state_r == wake_pkg::ST_DETACHED && link_rise) |=> o_usb_attach)
    else $error("no reattach on plug");
endmodule

// ==== test/wake_ctrl_model.sv ====
// Controller model: sees the wake line, powers host, sets mode, pulses clear
`timescale 1ns/10ps
module wake_ctrl_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_line,
  input wire logic i_pol,
  input wire logic i_arm,
  input wire logic i_keep,
  input wire logic i_slow,
  output logic o_bus_power_detect,
  output logic o_mode_select,
  output logic o_chip_reset_n,
  output logic [3:0] o_clears
);
  logic [2:0] step_r;
  logic [3:0] cnt_r;
  // power first, then mode select, then clear
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      step_r <= 3'h0;
      cnt_r <= 4'h0;
      o_bus_power_detect <= 1'b0;
      o_mode_select <= 1'b0;
      o_chip_reset_n <= 1'b1;
      o_clears <= 4'h0;
    end else begin
      case (step_r)
        3'h0: if (i_arm && i_line == i_pol) begin
          step_r <= 3'h1;
          cnt_r <= i_slow ? 4'hF : 4'h0;
        end
        3'h1: if (cnt_r == 4'h0) begin
          o_bus_power_detect <= 1'b1;
          step_r <= 3'h2;
        end else begin
          cnt_r <= cnt_r - 4'h1;
        end
        3'h2: begin
          o_mode_select <= i_keep;
          step_r <= 3'h3;
        end
        3'h3: begin
          o_chip_reset_n <= 1'b0;
          cnt_r <= 4'h1;
          step_r <= 3'h4;
        end
        3'h4: if (cnt_r == 4'h0) begin
          o_chip_reset_n <= 1'b1;
          o_clears <= o_clears + 4'h1;
          step_r <= 3'h5;
        end else begin
          cnt_r <= cnt_r - 4'h1;
        end
        default: if (i_line != i_pol) begin
          step_r <= 3'h0;
        end
      endcase
    end
  end
endmodule

// ==== test/usb_ether_wake_event_signaler_tb_top.sv ====
// Self-checking bench for the wake-event signaller
`timescale 1ns/10ps
module usb_ether_wake_event_signaler_tb_top;
  logic clk, rst_n, ee_ok, wol, da_v, link, wr, rd, arm, keep, slow;
  logic [11:0] gpio_r;
  logic [11:0] gpio_in;
  logic [47:0] da;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic pin, oe, reload, attach, lowp, wmode, bpd, msel, crst_n, line;
  logic [3:0] clears;
  int errors, n_compared, cyc, n_reload;
  // Pin 6 comes from the controller; open-drain line idles high
  assign gpio_in = {gpio_r[11:7], msel, gpio_r[5:0]};
  assign line = oe ? pin : 1'b1;
  usb_ether_wake_event_signaler dut (.i_clk(clk), .i_reset_n(rst_n), .i_chip_reset_n(crst_n),
    .i_gpio(gpio_in), .i_bus_power_detect(bpd), .i_eeprom_valid(ee_ok), .i_wol_pkt(wol),
    .i_rx_da_valid(da_v), .i_rx_da(da), .i_link_up(link), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_wake_event_pin(pin), .o_wake_event_pin_oe(oe),
    .o_reload_req(reload), .o_usb_attach(attach), .o_low_power(lowp), .o_wake_mode(wmode));
  wake_ctrl_model ctl (.i_clk(clk), .i_reset_n(rst_n), .i_line(line), .i_pol(1'b1),
    .i_arm(arm), .i_keep(keep), .i_slow(slow), .o_bus_power_detect(bpd),
    .o_mode_select(msel), .o_chip_reset_n(crst_n), .o_clears(clears));
  // Clock, hang limit and reload pulse count
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (reload === 1'b1) n_reload++;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(48'(rdata & m), 48'(e));
  endtask
  task automatic wait_pin(input logic e);
    repeat (5) @(posedge clk);
    check(48'({pin, oe}), 48'({e, 1'b1}));
  endtask
  task automatic ctl_clear(input logic k);
    logic [3:0] c0;
    c0 = clears;
    keep <= k;
    arm <= 1'b1;
    for (int i = 0; i < 60 && clears == c0; i++) @(posedge clk);
    arm <= 1'b0;
    check(48'(clears), 48'(c0 + 4'h1));
    repeat (3) @(posedge clk);
  endtask
  task automatic pulse_wol;
    @(posedge clk);
    wol <= 1'b1;
    @(posedge clk);
    wol <= 1'b0;
  endtask
  task automatic send_da(input logic [47:0] d);
    @(posedge clk);
    da <= d;
    da_v <= 1'b1;
    @(posedge clk);
    da_v <= 1'b0;
  endtask
  task automatic final_report;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    {rst_n, wol, da_v, link, wr, rd, arm, slow} = '0;
    {ee_ok, keep} = 2'b11;
    gpio_r = 12'hFFF;
    da = 48'h0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values and an unmapped read
    rd_chk(wake_pkg::OFS_CFG, 32'hFFFFFFFF, 32'h0);
    rd_chk(wake_pkg::OFS_PULSE, 32'hFF, 32'h10);
    rd_chk(wake_pkg::OFS_WAKE_EN, 32'hFFF, 32'h0);
    rd_chk(wake_pkg::OFS_PIN_POL, 32'hFFF, 32'h0);
    rd_chk(wake_pkg::OFS_STATUS, 32'h2F, 32'h0);
    rd_chk(8'h40, 32'hFFFFFFFF, 32'h0);
    check(48'({attach, lowp, wmode}), 48'h4);
    // entry refused without self power or without a valid store
    wr_reg(wake_pkg::OFS_CFG, 32'h0D);
    wr_reg(wake_pkg::OFS_CTRL, 32'h1);
    pulse_wol();
    wait_pin(1'b0);
    check(48'(wmode), 48'h0);
    wr_reg(wake_pkg::OFS_CFG, 32'h2D);
    ee_ok <= 1'b0;
    wr_reg(wake_pkg::OFS_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    check(48'(wmode), 48'h0);
    ee_ok <= 1'b1;
    wr_reg(wake_pkg::OFS_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    check(48'(wmode), 48'h1);
    rd_chk(wake_pkg::OFS_STATUS, 32'h9, 32'h9);
    // packet wake held as a level until a slow clear
    pulse_wol();
    wait_pin(1'b1);
    repeat (30) @(posedge clk);
    check(48'({pin, oe}), 48'h3);
    slow <= 1'b1;
    ctl_clear(1'b1);
    slow <= 1'b0;
    check(48'(n_reload), 48'h1);
    check(48'({wmode, pin}), 48'h2);
    rd_chk(wake_pkg::OFS_STATUS, 32'h30, 32'h30);
    // each capable pin wakes when low and enabled
    for (int p = 0; p < 11; p++) begin
      if (p != 5 && p != 6) begin
        wr_reg(wake_pkg::OFS_WAKE_EN, 32'h1 << p);
        gpio_r <= ~(12'h001 << p);
        wait_pin(1'b1);
        gpio_r <= 12'hFFF;
        ctl_clear(1'b1);
      end
    end
    // signalling pin and pin 11 never wake, disabled pin ignored
    wr_reg(wake_pkg::OFS_WAKE_EN, 32'h820);
    gpio_r <= 12'h757;
    wait_pin(1'b0);
    gpio_r <= 12'hFFF;
    // exact address match only, packet ignored in address mode
    wr_reg(wake_pkg::OFS_MAC_LO, 32'h89ABCDEF);
    wr_reg(wake_pkg::OFS_MAC_HI, 32'h4567);
    wr_reg(wake_pkg::OFS_CFG, 32'h3D);
    send_da(48'h456789ABCDEE);
    pulse_wol();
    wait_pin(1'b0);
    send_da(48'h456789ABCDEF);
    wait_pin(1'b1);
    ctl_clear(1'b0);
    check(48'(wmode), 48'h0);
    wr_reg(wake_pkg::OFS_CFG, 32'h2D);
    wr_reg(wake_pkg::OFS_CTRL, 32'h1);
    @(posedge clk);
    link <= 1'b1;
    wait_pin(1'b1);
    ctl_clear(1'b0);
    // Pulse style, open drain, active low: four cycles then released
    wr_reg(wake_pkg::OFS_PULSE, 32'h04);
    wr_reg(wake_pkg::OFS_CFG, 32'h23);
    wr_reg(wake_pkg::OFS_CTRL, 32'h1);
    pulse_wol();
    repeat (2) @(posedge clk);
    check(48'({pin, oe}), 48'h1);
    repeat (4) @(posedge clk);
    check(48'({pin, oe, line}), 48'h5);
    ctl_clear(1'b0);
    check(48'(wmode), 48'h0);
    // cable detach, then cable or pin reattach
    wr_reg(wake_pkg::OFS_WAKE_EN, 32'h004);
    wr_reg(wake_pkg::OFS_CFG, 32'h6D);
    for (int k = 0; k < 2; k++) begin
      link <= 1'b0;
      repeat (3) @(posedge clk);
      check(48'({attach, lowp}), 48'h1);
      if (k == 0) link <= 1'b1;
      else gpio_r[2] <= 1'b0;
      repeat (4) @(posedge clk);
      check(48'({attach, lowp}), 48'h2);
      gpio_r[2] <= 1'b1;
    end
    final_report();
  end
endmodule
